// ---- verilog/phd_hub.sv ----
// peripheral hub: spoke router, descriptor store and dma engine
`timescale 1ns/1ns
`default_nettype none
`include "phd_defs.svh"
module phd_hub
   import phd_pkg::*;
(
   input  wire logic     ref_clk,                        // system clock
   input  wire logic     rst,                            // sync reset
   input  wire phd_req_t cpu_req,                        // processor access
   output phd_rsp_t      cpu_rsp,                        // processor answer
   output phd_req_t      spk_req [`PHD_NSPK],            // spoke requests
   input  wire phd_rsp_t spk_rsp [`PHD_NSPK],            // spoke answers
   input  wire logic [`PHD_NCH-1:0] hw_trig,             // routed triggers
   input  wire logic [`PHD_NCH-1:0] cpu_trig,            // processor trig
   input  wire logic [`PHD_NCH-1:0] chain_en,            // chain trig on
   input  wire logic [4:0] chain_sel [`PHD_NCH],         // chain source
   input  wire logic [6:0] first_td [`PHD_NCH],          // first descr.
   input  wire logic [2:0] chan_prio [`PHD_NCH],         // priority
   input  wire logic [`PHD_NCH-1:0] rr_off,              // head of line
   input  wire logic     fair_en,                        // fairness on
   input  wire logic [`PHD_NCH-1:0] chan_stall,          // stall level
   input  wire logic [`PHD_NCH-1:0] chan_cancel,         // cancel pulse
   input  wire logic     boot_load,                      // boot load pulse
   output logic          boot_busy,                      // boot running
   output logic [`PHD_NCH-1:0] chan_busy,                // channel pending
   output logic [`PHD_NCH-1:0] chan_done,                // chain end pulse
   output logic [`PHD_NCH-1:0] term_out0,                // first irq
   output logic [`PHD_NCH-1:0] term_out1                 // second irq
);
   // ==========================================================
   // state
   logic [31:0]         td_mem [0:`PHD_NTDW-1];
   logic [6:0]          ch_td [`PHD_NCH];
   logic [31:0]         ch_src [`PHD_NCH];
   logic [31:0]         ch_dst [`PHD_NCH];
   logic [16:0]         ch_left [`PHD_NCH];
   logic [`PHD_NCH-1:0] ch_pend, ch_loaded;
   logic [`PHD_NCH-1:0] t1, t2, t3, tacc;
   phd_st_t             st;
   logic [4:0]          act, rr_ptr, gnt;
   logic [5:0]          slot;
   logic [31:0]         src, dst, hold;
   logic [16:0]         left;
   logic [6:0]          rd_bl, wr_bl;
   logic [1:0]          wid;
   logic                sinc, dinc, endl, hold_vld;

   // ==========================================================
   // live descriptor fields; read at load and at save, so a
   // descriptor patched by an earlier one takes effect
   wire [31:0] w0 = td_mem[{ch_td[act], 2'h0}];
   wire [31:0] w1 = td_mem[{ch_td[act], 2'h1}];
   wire [31:0] w2 = td_mem[{ch_td[act], 2'h2}];
   wire [31:0] w3 = td_mem[{ch_td[act], 2'h3}];
   wire [15:0] f_len = w2[`PHD_LEN_MSB:0];
   wire [6:0]  f_bst = w2[`PHD_BST_MSB:`PHD_BST_LSB];
   wire [6:0]  f_nxt = w3[`PHD_NXT_MSB:0];
   wire        f_hasn = w3[`PHD_HASN_BIT];
   wire [16:0] len_td = (f_len == 16'h0) ? `PHD_LEN_MAX
                                         : {1'b0, f_len};
   wire [16:0] load_left = ch_loaded[act] ? ch_left[act] : len_td;
   wire [6:0]  bst_eff = (f_bst == 7'h0) ? `PHD_BST_MAX : f_bst;
   wire        short = !w2[`PHD_ENDL_BIT] &&
                       (load_left < {10'h0, bst_eff});
   wire [6:0]  bl = short ? load_left[6:0] : bst_eff;
   wire [16:0] bw = {15'h0, wid} + 17'h1;
   wire        td_end = !endl && (left == 17'h0);
   wire        sv_end = (st == ST_SAVE) && td_end &&
                        !chan_cancel[act];

   // ==========================================================
   // dma master requests
   wire wr_vld = (st == ST_XFER) && hold_vld;
   wire rd_vld = (st == ST_XFER) && (rd_bl != 7'h0) &&
                 (!hold_vld || wr_vld);
   wire [16:0] rd_nx = phd_dec({10'h0, rd_bl}, bw);
   wire [16:0] wr_nx = phd_dec({10'h0, wr_bl}, bw);
   wire phd_req_t rd_r = {rd_vld, 1'b0, wid, src, 32'h0};
   wire phd_req_t wr_r = {wr_vld, 1'b1, wid, dst, hold};
   wire [2:0] cpu_spk = phd_spoke(cpu_req.addr);
   wire [2:0] rd_spk = phd_spoke(src);
   wire [2:0] wr_spk = phd_spoke(dst);

   // ==========================================================
   // spoke router
   phd_req_t            sel_s [`PHD_NSPK];
   phd_rsp_t            rsp_s [`PHD_NSPK];
   logic [`PHD_NSPK-1:0] cpu_hit, own_rd, loc_s, any_s;
   genvar s;
   generate
      for (s = 0; s < `PHD_NSPK; s++)
      begin : g_spk
         wire c_h = cpu_req.vld && (cpu_spk == 3'(s));
         wire w_h = wr_vld && (wr_spk == 3'(s));
         wire r_h = rd_vld && (rd_spk == 3'(s));
         assign cpu_hit[s] = c_h;
         assign own_rd[s] = r_h && !c_h && !w_h;
         assign any_s[s] = c_h || w_h || r_h;
         // processor first, then the older write beat
         assign sel_s[s] = c_h ? cpu_req : (w_h ? wr_r : rd_r);
         assign loc_s[s] = (3'(s) == `PHD_SPK_CFG) &&
                           sel_s[s].addr[`PHD_LOC_BIT];
         assign spk_req[s] = (any_s[s] && !loc_s[s] &&
                              3'(s) != `PHD_SPK_RSV) ? sel_s[s] : '0;
         assign rsp_s[s] = (3'(s) == `PHD_SPK_RSV) ?
                              {1'b1, 1'b1, 32'h0} :
                           loc_s[s] ? {1'b1, 1'b0, td_mem[
                              sel_s[s].addr[`PHD_TDW_MSB:`PHD_TDW_LSB]]}
                                    : spk_rsp[s];
      end
   endgenerate

   assign cpu_rsp = cpu_req.vld ? rsp_s[cpu_spk] : '0;
   wire wr_go = wr_vld && !cpu_hit[wr_spk] && rsp_s[wr_spk].rdy;
   wire rd_go = rd_vld && own_rd[rd_spk] && rsp_s[rd_spk].rdy &&
                (!hold_vld || wr_go);
   wire loc_wr = any_s[`PHD_SPK_CFG] && loc_s[`PHD_SPK_CFG] &&
                 sel_s[`PHD_SPK_CFG].wr;

   // descriptor store, written by processor or by a dma beat
   always_ff @(posedge ref_clk)
   begin
      if (loc_wr)
         td_mem[sel_s[`PHD_SPK_CFG].addr[`PHD_TDW_MSB:`PHD_TDW_LSB]]
            <= sel_s[`PHD_SPK_CFG].wdata;
   end

   // ==========================================================
   // triggers
   logic [`PHD_NCH-1:0] chain_hit;
   genvar c;
   generate
      for (c = 0; c < `PHD_NCH; c++)
      begin : g_chain
         assign chain_hit[c] = chain_en[c] &&
                               (chain_sel[c] < 5'(`PHD_NCH)) &&
                               chan_done[chain_sel[c]];
      end
   endgenerate
   // routed edge counts once the last two stages agree
   wire [`PHD_NCH-1:0] t_rise = ~(t2 ^ t3) & t3 & ~tacc;
   wire [`PHD_NCH-1:0] trig = t_rise | cpu_trig | chain_hit |
      (boot_load ? (`PHD_NCH'(1) << `PHD_BOOT_CH) : '0);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         t1 <= '0;
         t2 <= '0;
         t3 <= '0;
         tacc <= '0;
      end
      else
      begin
         t1 <= hw_trig;
         t2 <= t1;
         t3 <= t2;
         tacc <= (~(t2 ^ t3) & t3) | ((t2 ^ t3) & tacc);
      end
   end

   // ==========================================================
   // arbiter
   wire [`PHD_NCH-1:0] elig = ch_pend & ~chan_stall & ~chan_cancel;
   logic [7:0] lvl_any;
   logic [2:0] lo, fav, win;
   logic       found;
   always_comb
   begin
      lvl_any = '0;
      for (int i = 0; i < `PHD_NCH; i++)
         if (elig[i])
            lvl_any[chan_prio[i]] = 1'b1;
      lo = `PHD_LVL_LOW;
      for (int l = 7; l >= 0; l--)
         if (lvl_any[l])
            lo = 3'(l);
      fav = `PHD_LVL_LOW;
      for (int b = 5; b >= 0; b--)
         if (slot[b])
            fav = 3'(b) + `PHD_LVL_FAIR0;
      win = lo;
      if (fair_en && lo > `PHD_LVL_EXEMPT && lvl_any[fav])
         win = fav;
      gnt = 5'h0;
      found = 1'b0;
      for (int i = 0; i < `PHD_NCH; i++)
         if (!found && elig[i] && rr_off[i] && chan_prio[i] == win)
         begin
            gnt = 5'(i);
            found = 1'b1;
         end
      for (int k = 1; k <= `PHD_NCH; k++)
         if (!found && elig[(32'(rr_ptr) + k) % `PHD_NCH] &&
             chan_prio[(32'(rr_ptr) + k) % `PHD_NCH] == win)
         begin
            gnt = 5'((32'(rr_ptr) + k) % `PHD_NCH);
            found = 1'b1;
         end
   end

   // ==========================================================
   // engine
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st <= ST_IDLE;
         {act, rr_ptr, slot} <= '0;
         {src, dst, hold, left, rd_bl, wr_bl} <= '0;
         {wid, sinc, dinc, endl, hold_vld} <= '0;
         {chan_done, term_out0, term_out1} <= '0;
      end
      else
      begin
         chan_done <= '0;
         term_out0 <= '0;
         term_out1 <= '0;
         case (st)
            ST_IDLE:
               if (|elig)
               begin
                  act <= gnt;
                  rr_ptr <= gnt;
                  slot <= slot + 6'h1;
                  st <= ST_LOAD;
               end
            ST_LOAD:
            begin
               src <= ch_loaded[act] ? ch_src[act] : w0;
               dst <= ch_loaded[act] ? ch_dst[act] : w1;
               left <= load_left;
               rd_bl <= bl;
               wr_bl <= bl;
               wid <= w2[`PHD_WID_MSB:`PHD_WID_LSB];
               sinc <= w2[`PHD_SINC_BIT];
               dinc <= w2[`PHD_DINC_BIT];
               endl <= w2[`PHD_ENDL_BIT];
               hold_vld <= 1'b0;
               st <= ST_XFER;
            end
            ST_XFER:
            begin
               if (rd_go)
               begin
                  hold <= rsp_s[rd_spk].rdata;
                  src <= sinc ? src + 32'(bw) : src;
                  rd_bl <= rd_nx[6:0];
               end
               if (wr_go)
               begin
                  dst <= dinc ? dst + 32'(bw) : dst;
                  wr_bl <= wr_nx[6:0];
                  left <= endl ? left : phd_dec(left, bw);
               end
               hold_vld <= rd_go || (hold_vld && !wr_go);
               // a cancel cuts the burst in the cycle it is seen; a held read beat is dropped unless its write goes in that cycle
               if (chan_cancel[act] ||
                   (wr_go && {10'h0, wr_bl} <= bw))
                  st <= ST_SAVE;
            end
            ST_SAVE:
            begin
               if (sv_end)
               begin
                  term_out0 <= w3[`PHD_IRQ0_BIT] ?
                               (`PHD_NCH'(1) << act) : '0;
                  term_out1 <= w3[`PHD_IRQ1_BIT] ?
                               (`PHD_NCH'(1) << act) : '0;
                  chan_done <= f_hasn ? '0 : (`PHD_NCH'(1) << act);
               end
               st <= ST_IDLE;
            end
            default:
               st <= ST_IDLE;
         endcase
      end
   end

   // per channel progress; a trigger in the save cycle is kept
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ch_pend <= '0;
         ch_loaded <= '0;
         for (int i = 0; i < `PHD_NCH; i++)
            ch_td[i] <= 7'h0;
      end
      else
         for (int i = 0; i < `PHD_NCH; i++)
            if (chan_cancel[i])
            begin
               ch_pend[i] <= 1'b0;
               ch_loaded[i] <= 1'b0;
            end
            else if (st == ST_SAVE && act == 5'(i))
            begin
               ch_loaded[i] <= !td_end;
               ch_src[i] <= src;
               ch_dst[i] <= dst;
               ch_left[i] <= left;
               if (td_end && f_hasn)
                  ch_td[i] <= f_nxt;
               else if (td_end && trig[i])
                  ch_td[i] <= first_td[i];
               else if (td_end)
                  ch_pend[i] <= 1'b0;
            end
            else if (trig[i] && !ch_pend[i])
            begin
               ch_pend[i] <= 1'b1;
               ch_td[i] <= first_td[i];
            end
   end

   assign chan_busy = ch_pend;
   assign boot_busy = ch_pend[`PHD_BOOT_CH];

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_cpu_first;
      cpu_req.vld && wr_vld && cpu_spk == wr_spk |-> !wr_go;
   endproperty
   a_cpu_first: assert property (p_cpu_first)
      else $error("dma write beat taken over processor");

   property p_par;
      wr_vld && cpu_req.vld && cpu_spk != wr_spk && !loc_s[wr_spk] &&
      wr_spk != `PHD_SPK_RSV |-> spk_req[wr_spk].vld && spk_req[wr_spk].wr;
   endproperty
   a_par: assert property (p_par)
      else $error("dma write held back by processor on other spoke");

   property p_rdwr;
      rd_vld && wr_vld && rd_spk != wr_spk && !cpu_hit[rd_spk]
      |-> own_rd[rd_spk];
   endproperty
   a_rdwr: assert property (p_rdwr)
      else $error("read not overlapped with write");

   property p_rsv;
      cpu_req.vld && cpu_spk == `PHD_SPK_RSV |-> cpu_rsp.err && cpu_rsp.rdy;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved spoke not refused");

   sequence s_save_end;
      st == ST_SAVE && sv_end;
   endsequence
   property p_idle_end;
      s_save_end and !f_hasn and !trig[act] |=> !ch_pend[act] && chan_done != '0;
   endproperty
   a_idle_end: assert property (p_idle_end)
      else $error("channel not idled at chain end");

   property p_link;
      s_save_end and f_hasn |=> ch_td[act] == $past(f_nxt) && ch_pend[act];
   endproperty
   a_link: assert property (p_link)
      else $error("successor descriptor not taken");

   property p_preempt;
      !$stable(act) |-> $past(st) == ST_IDLE;
   endproperty
   a_preempt: assert property (p_preempt)
      else $error("channel switched inside a burst");

   property p_stall;
      st == ST_IDLE && |elig |-> !chan_stall[gnt] ##1 st == ST_LOAD;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stalled channel granted");

   property p_strict;
      st == ST_IDLE && |elig && !fair_en
      |-> !(|(lvl_any & ((8'h01 << chan_prio[gnt]) - 8'h01)));
   endproperty
   a_strict: assert property (p_strict)
      else $error("lower priority granted over higher");

   property p_fair;
      st == ST_IDLE && |elig && fair_en && lo > `PHD_LVL_EXEMPT &&
      lvl_any[fav] |-> chan_prio[gnt] == fav;
   endproperty
   a_fair: assert property (p_fair)
      else $error("favoured level not granted");
endmodule : phd_hub
`default_nettype wire

// ---- pkg/phd_defs.svh ----
// constants of the peripheral hub and its dma controller
`ifndef PHD_DEFS_SVH
`define PHD_DEFS_SVH
`define PHD_NCH        24
`define PHD_NSPK       8
`define PHD_NTDW       512
`define PHD_SPK_MSB    26
`define PHD_SPK_LSB    24
`define PHD_SPK_CFG    3'h2
`define PHD_SPK_RSV    3'h5
`define PHD_LOC_BIT    23
`define PHD_TDW_MSB    10
`define PHD_TDW_LSB    2
`define PHD_BOOT_CH    5'h00
`define PHD_LVL_EXEMPT 3'h1
`define PHD_LVL_FAIR0  3'h2
`define PHD_LVL_LOW    3'h7
`define PHD_LEN_MSB    15
`define PHD_ENDL_BIT   16
`define PHD_BST_MSB    23
`define PHD_BST_LSB    17
`define PHD_WID_MSB    25
`define PHD_WID_LSB    24
`define PHD_SINC_BIT   26
`define PHD_DINC_BIT   27
`define PHD_NXT_MSB    6
`define PHD_HASN_BIT   7
`define PHD_IRQ0_BIT   8
`define PHD_IRQ1_BIT   9
`define PHD_LEN_MAX    17'h10000
`define PHD_BST_MAX    7'h7F
`endif

// ---- pkg/phd_pkg.sv ----
// types and decoders of the peripheral hub
`include "phd_defs.svh"
package phd_pkg;
   typedef struct packed {
      logic        vld;
      logic        wr;
      logic [1:0]  sz;
      logic [31:0] addr;
      logic [31:0] wdata;
   } phd_req_t;
   typedef struct packed {
      logic        rdy;
      logic        err;
      logic [31:0] rdata;
   } phd_rsp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_XFER, ST_SAVE} phd_st_t;

   function automatic logic [2:0] phd_spoke(input logic [31:0] a);
      return a[`PHD_SPK_MSB:`PHD_SPK_LSB];
   endfunction : phd_spoke

   function automatic logic [16:0] phd_dec(input logic [16:0] a,
                                           input logic [16:0] b);
      return (a > b) ? 17'(a - b) : 17'h0;
   endfunction : phd_dec
endpackage : phd_pkg

// ---- bench/phd_spoke_mem.sv ----
// spoke slave model: one-cycle memory, optionally answering every other cycle
`timescale 1ns/1ns
`default_nettype none
module phd_spoke_mem
   import phd_pkg::*;
#(
   parameter bit SLOW = 1'b0
)
(
   input  wire logic     ref_clk, // system clock
   input  wire phd_req_t req,     // request from the hub
   output phd_rsp_t      rsp      // answer to the hub
);
   // ==========================================================
   // storage and answer
   logic [31:0]      mem [64];
   logic [31:0]      last = 32'h0;
   logic             ph   = 1'b0;
   wire logic [5:0]  idx  = req.addr[7:2];
   wire logic        go   = req.vld && (!SLOW || ph);
   // idle data is inverted so a stale read never looks valid
   assign rsp = '{go, 1'b0, go ? mem[idx] : ~last};
   always_ff @(posedge ref_clk)
   begin
      ph <= ~ph;
      if (go)
         last <= rsp.rdata;
      if (go && req.wr)
         mem[idx] <= req.wdata;
   end
endmodule : phd_spoke_mem
`default_nettype wire

// ---- bench/peripheral_hub_dma_tb.sv ----
// self-checking bench of the peripheral hub and dma engine
`timescale 1ns/1ns
`default_nettype none
`include "phd_defs.svh"
module peripheral_hub_dma_tb
   import phd_pkg::*;
;
   // ==========================================================
   // signals
   localparam logic [31:0] TDB = 32'h0280_0000;
   logic                ref_clk = 1'b0;
   logic                rst = 1'b1;
   phd_req_t            cpu_req = '0;
   phd_rsp_t            cpu_rsp;
   phd_req_t            spk_req [`PHD_NSPK];
   phd_rsp_t            spk_rsp [`PHD_NSPK];
   logic [`PHD_NCH-1:0] hw_trig = '0, cpu_trig = '0, chain_en = 24'h000010;
   logic [`PHD_NCH-1:0] rr_off = '0, chan_stall = 24'h001000;
   logic [`PHD_NCH-1:0] chan_cancel = '0;
   logic [4:0]          chain_sel [`PHD_NCH];
   logic [6:0]          first_td [`PHD_NCH];
   logic [2:0]          chan_prio [`PHD_NCH];
   logic                fair_en = 1'b0, boot_load = 1'b0, boot_busy;
   logic [`PHD_NCH-1:0] chan_busy, chan_done, term_out0, term_out1;
   int                  fails = 0, n_checks = 0, lw = 0, cyc = 0;
   logic [31:0]         q;
   logic                e;

   phd_hub u_dut (.ref_clk, .rst, .cpu_req, .cpu_rsp, .spk_req, .spk_rsp,
      .hw_trig, .cpu_trig, .chain_en, .chain_sel, .first_td, .chan_prio,
      .rr_off, .fair_en, .chan_stall, .chan_cancel, .boot_load, .boot_busy,
      .chan_busy, .chan_done, .term_out0, .term_out1);
   for (genvar s = 0; s < `PHD_NSPK; s++)
   begin : g_spk
      phd_spoke_mem #(.SLOW(s == 3)) u_mem (.ref_clk(ref_clk),
         .req(spk_req[s]), .rsp(spk_rsp[s]));
   end

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // hang guard, well above the several hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   // ==========================================================
   // tasks
   task automatic chk(input string n, input logic [31:0] s, x);
      n_checks++;
      if (s !== x)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   // request held until rdy is seen high at an edge
   task automatic cpu(input logic w, input logic [31:0] a, d);
      lw = 0;
      @(posedge ref_clk);
      cpu_req <= '{1'b1, w, 2'h3, a, d};
      @(posedge ref_clk);
      while (cpu_rsp.rdy !== 1'b1 && lw < 50)
      begin
         lw++;
         @(posedge ref_clk);
      end
      if (lw >= 50)
         fails++;
      q = cpu_rsp.rdata;
      e = cpu_rsp.err;
      cpu_req <= '0;
   endtask : cpu

   task automatic rd(input string n, input logic [31:0] a, x);
      cpu(1'b0, a, 32'h0);
      chk(n, q, x);
   endtask : rd

   // four-byte beats, eight-byte bursts so beats overlap
   task automatic td(input logic [6:0] t, input logic [31:0] s, d,
                     input logic [15:0] len, input logic [9:0] lnk,
                     input logic endl);
      logic [31:0] b;
      b = TDB + {21'h0, t, 4'h0};
      cpu(1'b1, b, s);
      cpu(1'b1, b + 32'h4, d);
      cpu(1'b1, b + 32'h8, {4'h0, 4'hF, 7'h08, endl, len});
      cpu(1'b1, b + 32'hC, {22'h0, lnk});
   endtask : td

   task automatic trig(input logic [`PHD_NCH-1:0] m);
      @(posedge ref_clk);
      cpu_trig <= m;
      @(posedge ref_clk);
      cpu_trig <= '0;
   endtask : trig

   // done seen, channel idle and the two terminal pulses as expected
   task automatic wdone(input int c, input string n, input logic [1:0] x);
      int k;
      k = 0;
      while (chan_done[c] !== 1'b1 && k < 3000)
      begin
         @(posedge ref_clk);
         k++;
      end
      chk(n, {28'h0, k < 3000, chan_busy[c], term_out1[c], term_out0[c]},
          {28'h0, 2'b10, x});
   endtask : wdone

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // ==========================================================
   // tests
   initial
   begin
      for (int c = 0; c < `PHD_NCH; c++)
      begin
         chain_sel[c] = 5'h03;
         first_td[c] = 7'h00;
         chan_prio[c] = 3'h4;
      end
      first_td[4] = 7'h01;
      first_td[10] = 7'h04;
      first_td[11] = 7'h06;
      first_td[0] = 7'h07;
      first_td[12] = 7'h08;
      first_td[8] = 7'h09;
      first_td[9] = 7'h0A;
      chan_prio[8] = 3'h7;
      chan_prio[9] = 3'h0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      for (int s = 0; s < 8; s++)
         if (s != 5)
            cpu(1'b1, {5'h0, 3'(s), 24'h10}, 32'hA500_0000 + 32'(s));
      for (int s = 0; s < 8; s++)
         if (s != 5)
            rd("spoke_map", {5'h0, 3'(s), 24'h10}, 32'hA500_0000 + 32'(s));
      cpu(1'b0, 32'h0500_0000, 32'h0);
      chk("spoke5_err", {31'h0, e}, 32'h1);
      for (int i = 8; i < 32; i++)
         cpu(1'b1, 32'(i * 4), 32'h5A00_0000 + 32'(i * 4));
      cpu(1'b1, 32'h40, 32'h44);
      cpu(1'b1, 32'h0600_0060, 32'h0);
      td(0, 32'h20, 32'h0300_0020, 16'd16, 10'h100, 1'b0);
      td(1, 32'h30, 32'h0400_0030, 16'd4, 10'h082, 1'b0);
      td(2, 32'h34, 32'h0400_0034, 16'd4, 10'h200, 1'b0);
      td(4, 32'h40, TDB + 32'h50, 16'd4, 10'h085, 1'b0);
      td(5, 32'h48, 32'h0400_0040, 16'd4, 10'h000, 1'b0);
      td(6, 32'h50, 32'h0400_0050, 16'd4, 10'h300, 1'b0);
      td(7, 32'h58, 32'h0400_0058, 16'd4, 10'h100, 1'b0);
      td(8, 32'h60, 32'h0600_0060, 16'd4, 10'h088, 1'b1);
      td(9, 32'h20, 32'h0700_0020, 16'd16, 10'h000, 1'b0);
      td(10, 32'h20, 32'h0700_0040, 16'd16, 10'h000, 1'b0);
      // processor shares spokes with a running transfer
      trig(24'h000008);
      rd("cpu_sp0", 32'h2C, 32'h5A00_002C);
      chk("cpu_wait0", 32'(lw), 32'h0);
      rd("cpu_sp4", 32'h0400_0010, 32'hA500_0004);
      chk("cpu_wait4", 32'(lw), 32'h0);
      rd("cpu_sp3", 32'h0300_0010, 32'hA500_0003);
      wdone(3, "ch3_done", 2'b01);
      wdone(4, "ch4_chain", 2'b10);
      for (int i = 0; i < 16; i += 4)
         rd("ch3_data", 32'h0300_0020 + 32'(i), 32'h5A00_0020 + 32'(i));
      rd("ch4_td1", 32'h0400_0030, 32'h5A00_0030);
      rd("ch4_td2", 32'h0400_0034, 32'h5A00_0034);
      // address fetched into a later descriptor
      trig(24'h000400);
      wdone(10, "ch10_done", 2'b00);
      rd("patched_td", TDB + 32'h50, 32'h44);
      rd("indexed", 32'h0400_0040, 32'h5A00_0044);
      @(posedge ref_clk);
      hw_trig[11] <= 1'b1;
      wdone(11, "hw_trig", 2'b11);
      hw_trig[11] <= 1'b0;
      rd("hw_data", 32'h0400_0050, 32'h5A00_0050);
      @(posedge ref_clk);
      boot_load <= 1'b1;
      @(posedge ref_clk);
      boot_load <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("boot_busy", {31'h0, boot_busy}, 32'h1);
      wdone(0, "boot_done", 2'b01);
      rd("boot_data", 32'h0400_0058, 32'h5A00_0058);
      // stalled endless loop, resumed, then cancelled
      trig(24'h001000);
      repeat (30) @(posedge ref_clk);
      chk("stall_busy", {31'h0, chan_busy[12]}, 32'h1);
      rd("stall_hold", 32'h0600_0060, 32'h0);
      chan_stall[12] <= 1'b0;
      repeat (40) @(posedge ref_clk);
      rd("resumed", 32'h0600_0060, 32'h5A00_0060);
      chk("endless", {31'h0, chan_busy[12]}, 32'h1);
      chan_cancel[12] <= 1'b1;
      @(posedge ref_clk);
      chan_cancel[12] <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk("cancel", {31'h0, chan_busy[12]}, 32'h0);
      // level 0 served before level 7 when both are triggered together
      trig(24'h000300);
      wdone(9, "prio_hi", 2'b00);
      chk("prio_lo_wait", {31'h0, chan_busy[8]}, 32'h1);
      wdone(8, "prio_lo", 2'b00);
      rd("prio_data", 32'h0700_004C, 32'h5A00_002C);
      // fairness on: both low levels must still drain
      fair_en <= 1'b1;
      chan_prio[9] <= 3'h6;
      trig(24'h000300);
      repeat (60) @(posedge ref_clk);
      chk("fair_both", {30'h0, chan_busy[9:8]}, 32'h0);
      tally_and_finish();
   end
endmodule : peripheral_hub_dma_tb
`default_nettype wire
